// [arp_bus_reader.sv]
// Microprocessor bus reader model facing the result pins
`timescale 1ns/100ps

module arp_bus_reader (
   input  wire logic          clk,
   input  wire logic          chipOn,
   input  wire logic          wantHigh,
   input  wire logic          wantLow,
   output logic               masterEnable_n,
   output logic               highByteEnable_n,
   output logic               lowByteEnable_n,
   input  wire logic [11:0]   resultBits,
   input  wire logic [11:0]   resultOeN,
   input  wire logic          polarityFlag,
   input  wire logic          polarityOeN,
   input  wire logic          overrangeFlag,
   input  wire logic          overrangeOeN,
   output logic      [13:0]   busLine
);
   logic [13:0] lastBus;
   logic [13:0] pinVal;
   logic [13:0] pinOeN;

   assign masterEnable_n   = ~chipOn;
   assign highByteEnable_n = ~wantHigh;
   assign lowByteEnable_n  = ~wantLow;

   // Wire levels: released lines show the inverse of their last level
   assign pinVal = {overrangeFlag, polarityFlag, resultBits};
   assign pinOeN = {overrangeOeN, polarityOeN, resultOeN};
   always_comb begin
      for (int i = 0; i < 14; i++) begin
         busLine[i] = pinOeN[i] ? ~lastBus[i] : pinVal[i];
      end
   end

   // Last seen level of each line
   always_ff @(posedge clk) begin
      lastBus <= busLine;
   end
endmodule

// [arp_defs.svh]
// Offsets, field positions, reset values and codes of the result output port
`ifndef ARP_DEFS_SVH
`define ARP_DEFS_SVH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define ARP_ADDR_W          4
`define ARP_OFF_CTRL        4'h0
`define ARP_OFF_RESULT      4'h4
`define ARP_OFF_STATE       4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define ARP_CTRL_HOLD_BIT   0
`define ARP_RES_POL_BIT     12
`define ARP_RES_OVR_BIT     13
`define ARP_RES_STATUS_BIT  15
`define ARP_ST_ACTIVE_BIT   2
`define ARP_ST_COUNT_LSB    8

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define ARP_MAG_W           12
`define ARP_PIN_W           14
`define ARP_CTRL_HOLD_RST   1'b0
`define ARP_COUNT_RST       8'h00
`define ARP_MAG_RST         12'h000
`define ARP_OE_N_RST        14'h3FFF

// ****************************************************************
// Analog phase codes
// ****************************************************************
`define ARP_PH_AUTO_ZERO    2'h0
`define ARP_PH_INTEGRATE    2'h1
`define ARP_PH_DEINTEGRATE  2'h2
`define ARP_PH_ZERO_INTEG   2'h3

`endif

// [arp_output_bank.sv]
// Registered three-state output stage for the result pins
`timescale 1ns/100ps
`include "arp_defs.svh"

module arp_output_bank (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic [`ARP_PIN_W-1:0]     dataIn,
   input  wire logic [`ARP_PIN_W-1:0]     enIn,
   output logic      [`ARP_PIN_W-1:0]     dataOut,
   output logic      [`ARP_PIN_W-1:0]     oeNOut
);

   // ****************************************************************
   // Output flops
   // ****************************************************************

   // released when unselected
   // Enable is low while a pin drives
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dataOut <= '0;
         oeNOut  <= `ARP_OE_N_RST;
      end else begin
         dataOut <= dataIn;
         oeNOut  <= ~enIn;
      end
   end

endmodule

// [arp_pkg.sv]
// Types shared by the result output port files
package arp_pkg;

   // Conversion tracker states
   typedef enum logic [1:0] {
      ARP_CONV_IDLE   = 2'b01,
      ARP_CONV_ACTIVE = 2'b10
   } arp_conv_e;

   // Magnitude word
   typedef logic [11:0] arp_mag_t;

endpackage

// [arp_result_latch.sv]
// Holds one converted result: magnitude, polarity and overrange
`timescale 1ns/100ps
`include "arp_defs.svh"

module arp_result_latch (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              load,
   input  arp_pkg::arp_mag_t      magIn,
   input  wire logic              positiveIn,
   input  wire logic              overrangeIn,
   output arp_pkg::arp_mag_t      magOut,
   output logic                   polOut,
   output logic                   ovrOut
);

   // ****************************************************************
   // Latch storage
   // ****************************************************************

   // flags captured
   // All three fields move on the same edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         magOut <= `ARP_MAG_RST;
         polOut <= 1'b0;
         ovrOut <= 1'b0;
      end else if (load) begin
         magOut <= magIn;
         polOut <= positiveIn;   // High for positive input
         ovrOut <= overrangeIn;
      end
   end

endmodule

// [arp_result_port.sv]
// Result and status output stage of the integrating converter
//
// Operation
// - Status high from integrate until result latched
// - Status low in auto-zero or zero-integrator
// - Polarity flag high for positive input
// - Overrange flag high when range exceeded
// - Magnitude twelve bits, index 11 is MSB
// - Every result pin is three-state
// - High byte enable drives bits 9-12, flags
// - Low byte enable drives bits 1-8
// - Master enable high releases every result pin
`timescale 1ns/100ps
`include "arp_defs.svh"

module arp_result_port (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   // Analog section side
   input  wire logic [1:0]                analogPhase,
   input  wire logic                      convDone,
   input  arp_pkg::arp_mag_t              convMagnitude,
   input  wire logic                      convPositive,
   input  wire logic                      convOverrange,
   // Reader side pins
   input  wire logic                      masterEnable_n,
   input  wire logic                      highByteEnable_n,
   input  wire logic                      lowByteEnable_n,
   output logic                           statusOut,
   output logic                           polarityFlag,
   output logic                           polarityOeN,
   output logic                           overrangeFlag,
   output logic                           overrangeOeN,
   output logic      [`ARP_MAG_W-1:0]     resultBits,
   output logic      [`ARP_MAG_W-1:0]     resultOeN,
   // Avalon-MM slave
   input  wire logic [`ARP_ADDR_W-1:0]    avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   input  wire logic [3:0]                avs_byteenable,
   output logic      [31:0]               avs_readdata,
   output logic                           avs_waitrequest
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   arp_pkg::arp_conv_e          convState_r;
   arp_pkg::arp_conv_e          convState_nxt;
   logic                        ctrlHold_r;
   logic                        ack_r;
   logic [7:0]                  latchCount_r;
   logic                        latchFire;
   logic                        inZeroPhase;
   logic                        inSlopePhase;
   arp_pkg::arp_mag_t           latchMag;
   logic                        latchPol;
   logic                        latchOvr;
   logic [`ARP_PIN_W-1:0]       pinData;
   logic [`ARP_PIN_W-1:0]       pinEn;
   logic [`ARP_PIN_W-1:0]       bankData;
   logic [`ARP_PIN_W-1:0]       bankOeN;
   logic                        highOn;
   logic                        lowOn;

   // ****************************************************************
   // Functions
   // ****************************************************************

   // A byte group drives when master and its own enable are low
   function automatic logic byteSelected(input logic masterN, input logic byteN);
      byteSelected = !masterN && !byteN;
   endfunction

   // Register access decode
   function automatic logic hitOffset(input logic [`ARP_ADDR_W-1:0] addr,
                                      input logic [`ARP_ADDR_W-1:0] off);
      hitOffset = (addr == off);
   endfunction

   // ****************************************************************
   // Phase decode and latch event
   // ****************************************************************

   // Phase classes of the analog section
   assign inZeroPhase  = (analogPhase == `ARP_PH_AUTO_ZERO) || (analogPhase == `ARP_PH_ZERO_INTEG);
   assign inSlopePhase = (analogPhase == `ARP_PH_INTEGRATE) || (analogPhase == `ARP_PH_DEINTEGRATE);

   // Hold bit blocks new results from reaching the pins
   assign latchFire = convDone && !ctrlHold_r;

   // ****************************************************************
   // Conversion tracker
   // ****************************************************************

   // Next state of the tracker
   always_comb begin
      convState_nxt = convState_r;
      case (convState_r)
         arp_pkg::ARP_CONV_IDLE: begin
            if (analogPhase == `ARP_PH_INTEGRATE) begin
               convState_nxt = arp_pkg::ARP_CONV_ACTIVE;
            end
         end
         arp_pkg::ARP_CONV_ACTIVE: begin
            if (latchFire || inZeroPhase) begin
               convState_nxt = arp_pkg::ARP_CONV_IDLE;
            end
         end
         default: begin
            convState_nxt = arp_pkg::ARP_CONV_IDLE;
         end
      endcase
   end

   // Tracker state flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         convState_r <= arp_pkg::ARP_CONV_IDLE;
      end else begin
         convState_r <= convState_nxt;
      end
   end

   // status pin
   // Registered from the tracker's next state, so it changes on the same edge as the state flop
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         statusOut <= 1'b0;
      end else begin
         statusOut <= (convState_nxt == arp_pkg::ARP_CONV_ACTIVE);
      end
   end

   // Count of results taken, seen by software
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         latchCount_r <= `ARP_COUNT_RST;
      end else if (latchFire) begin
         latchCount_r <= latchCount_r + 8'h01;
      end
   end

   // ****************************************************************
   // Result latch and output stage
   // ****************************************************************

   arp_result_latch u_latch (
      .clk         (clk),
      .reset_n     (reset_n),
      .load        (latchFire),
      .magIn       (convMagnitude),
      .positiveIn  (convPositive),
      .overrangeIn (convOverrange),
      .magOut      (latchMag),
      .polOut      (latchPol),
      .ovrOut      (latchOvr)
   );

   assign highOn = byteSelected(masterEnable_n, highByteEnable_n);
   assign lowOn  = byteSelected(masterEnable_n, lowByteEnable_n);

   // pin order: {overrange, polarity, bit 12 .. bit 1}
   assign pinData = {latchOvr, latchPol, latchMag};
   assign pinEn   = {{6{highOn}}, {8{lowOn}}};

   arp_output_bank u_bank (
      .clk     (clk),
      .reset_n (reset_n),
      .dataIn  (pinData),
      .enIn    (pinEn),
      .dataOut (bankData),
      .oeNOut  (bankOeN)
   );

   // Split the bank into named pins
   assign resultBits    = bankData[`ARP_MAG_W-1:0];
   assign resultOeN     = bankOeN[`ARP_MAG_W-1:0];
   assign polarityFlag  = bankData[`ARP_MAG_W];
   assign polarityOeN   = bankOeN[`ARP_MAG_W];
   assign overrangeFlag = bankData[`ARP_MAG_W+1];
   assign overrangeOeN  = bankOeN[`ARP_MAG_W+1];

   // ****************************************************************
   // Avalon-MM slave
   // ****************************************************************

   // One wait cycle on every access
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

   // Control register write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrlHold_r <= `ARP_CTRL_HOLD_RST;
      end else if (avs_write && ack_r && avs_byteenable[0] && hitOffset(avs_address, `ARP_OFF_CTRL)) begin
         ctrlHold_r <= avs_writedata[`ARP_CTRL_HOLD_BIT];
      end
   end

   // Read data, zero for unmapped offsets
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_r) begin
         avs_readdata <= 32'h0000_0000;
         if (hitOffset(avs_address, `ARP_OFF_CTRL)) begin
            avs_readdata[`ARP_CTRL_HOLD_BIT] <= ctrlHold_r;
         end else if (hitOffset(avs_address, `ARP_OFF_RESULT)) begin
            avs_readdata[`ARP_MAG_W-1:0]       <= latchMag;
            avs_readdata[`ARP_RES_POL_BIT]     <= latchPol;
            avs_readdata[`ARP_RES_OVR_BIT]     <= latchOvr;
            avs_readdata[`ARP_RES_STATUS_BIT]  <= statusOut;
         end else if (hitOffset(avs_address, `ARP_OFF_STATE)) begin
            avs_readdata[1:0]                  <= analogPhase;
            avs_readdata[`ARP_ST_ACTIVE_BIT]   <= (convState_r == arp_pkg::ARP_CONV_ACTIVE);
            avs_readdata[`ARP_ST_COUNT_LSB+:8] <= latchCount_r;
         end
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_status_integ_rise: assert property (
      (analogPhase == `ARP_PH_INTEGRATE) && !latchFire |=> statusOut)
      else $error("status not high during integrate");

   a_status_until_latch: assert property (
      statusOut && inSlopePhase && !latchFire |=> statusOut)
      else $error("status dropped before latch");

   a_status_zero_low: assert property (
      inZeroPhase |=> !statusOut)
      else $error("status high in a zero phase");

   a_pol_follows: assert property (
      latchFire |=> ##1 (polarityFlag == $past(convPositive, 2)))
      else $error("polarity flag wrong after latch");

   a_ovr_follows: assert property (
      latchFire |=> ##1 (overrangeFlag == $past(convOverrange, 2)))
      else $error("overrange flag wrong after latch");

   a_mag_bit_order: assert property (
      latchFire |=> ##1 (resultBits == $past(convMagnitude, 2)))
      else $error("magnitude bits out of order");

   a_high_byte_drive: assert property (
      highOn |=> !polarityOeN && !overrangeOeN && (resultOeN[11:8] == 4'h0))
      else $error("high byte not driven");

   a_low_byte_drive: assert property (
      lowOn |=> (resultOeN[7:0] == 8'h00))
      else $error("low byte not driven");

   a_unselected_float: assert property (
      !lowOn |=> (resultOeN[7:0] == 8'hFF))
      else $error("low byte driven while unselected");

   a_high_float: assert property (
      !highOn |=> polarityOeN && overrangeOeN && (resultOeN[11:8] == 4'hF))
      else $error("high byte driven while unselected");

   a_status_latch_drop: assert property (
      latchFire && statusOut |=> !statusOut)
      else $error("status still high after latch");

   a_count_step: assert property (
      latchFire |=> (latchCount_r == $past(latchCount_r) + 8'h01))
      else $error("result count did not advance");

   a_master_release: assert property (
      masterEnable_n |=> (&resultOeN) && polarityOeN && overrangeOeN)
      else $error("pins driven with master enable high");

   a_single_update: assert property (
      !latchFire |=> ##1 $stable({overrangeFlag, polarityFlag, resultBits}))
      else $error("result pins moved without a latch");

   a_bus_answer: assert property (
      avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait longer than one cycle");

   c_latch_event: cover property (latchFire ##2 !resultOeN[0]);
   c_high_read: cover property (statusOut ##1 highOn ##1 !polarityOeN);
   c_status_cycle: cover property ((analogPhase == `ARP_PH_INTEGRATE) ##1 statusOut ##[1:20] !statusOut);
   c_hold_block: cover property (convDone && ctrlHold_r);

endmodule

// [arp_result_port_tb_top.sv]
// Self-checking bench for the result output port
`timescale 1ns/100ps
`include "arp_defs.svh"

module arp_result_port_tb_top;
   typedef struct {logic [11:0] mag; logic pos; logic ovr;} arp_row_s;

   logic                 clk, reset_n, convDone, convPositive, convOverrange;
   logic [1:0]           analogPhase;
   arp_pkg::arp_mag_t    convMagnitude;
   logic                 chipOn, wantHigh, wantLow;
   logic                 masterEnable_n, highByteEnable_n, lowByteEnable_n;
   logic                 statusOut, polarityFlag, polarityOeN, overrangeFlag, overrangeOeN;
   logic [11:0]          resultBits, resultOeN;
   logic [13:0]          busLine, lastPins;
   logic [3:0]           avs_address;
   logic                 avs_read, avs_write, avs_waitrequest;
   logic [31:0]          avs_writedata, avs_readdata, q;
   int                   mismatches, n_tests, nLatched;
   arp_row_s             rows [5] = '{'{12'hFFF, 1'b1, 1'b1}, '{12'h000, 1'b0, 1'b0},
                                      '{12'h800, 1'b1, 1'b0}, '{12'h001, 1'b0, 1'b1},
                                      '{12'hA5A, 1'b1, 1'b0}};

   arp_result_port uut (.clk(clk), .reset_n(reset_n), .analogPhase(analogPhase), .convDone(convDone),
      .convMagnitude(convMagnitude), .convPositive(convPositive), .convOverrange(convOverrange),
      .masterEnable_n(masterEnable_n), .highByteEnable_n(highByteEnable_n), .lowByteEnable_n(lowByteEnable_n),
      .statusOut(statusOut), .polarityFlag(polarityFlag), .polarityOeN(polarityOeN),
      .overrangeFlag(overrangeFlag), .overrangeOeN(overrangeOeN), .resultBits(resultBits),
      .resultOeN(resultOeN), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   arp_bus_reader reader (.clk(clk), .chipOn(chipOn), .wantHigh(wantHigh), .wantLow(wantLow),
      .masterEnable_n(masterEnable_n), .highByteEnable_n(highByteEnable_n), .lowByteEnable_n(lowByteEnable_n),
      .resultBits(resultBits), .resultOeN(resultOeN), .polarityFlag(polarityFlag), .polarityOeN(polarityOeN),
      .overrangeFlag(overrangeFlag), .overrangeOeN(overrangeOeN), .busLine(busLine));

   // ****************************************************************
   // Clock, watchdog and helpers
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Avalon transfer, held until waitrequest is seen low at an edge
   task automatic avXfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= ~wr;
      // Waitrequest is looked at only on rising edges
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask

   // One completed conversion, then time for latch and pins
   task automatic convert(input logic [11:0] m, input logic p, input logic o);
      convMagnitude <= m;
      convPositive  <= p;
      convOverrange <= o;
      convDone      <= 1'b1;
      @(posedge clk);
      convDone <= 1'b0;
      nLatched++;
      repeat (3) @(posedge clk);
   endtask

   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {reset_n, convDone, convPositive, convOverrange, chipOn, wantHigh, wantLow} = 7'h00;
      {analogPhase, convMagnitude, avs_address, avs_read, avs_write, avs_writedata} = '0;
      mismatches = 0;
      n_tests = 0;
      nLatched = 0;
      repeat (12) @(posedge clk);
      chk({overrangeOeN, polarityOeN, resultOeN, statusOut}, 15'h7FFE, "reset pins");
      reset_n  <= 1'b1;
      chipOn   <= 1'b1;
      wantHigh <= 1'b1;
      wantLow  <= 1'b1;
      repeat (3) @(posedge clk);
      // Table of results read on the pins and in the register
      foreach (rows[i]) begin
         convert(rows[i].mag, rows[i].pos, rows[i].ovr);
         chk(busLine, {rows[i].ovr, rows[i].pos, rows[i].mag}, "pins");
         avXfer(1'b0, `ARP_OFF_RESULT, 32'h0, q);
         chk(q, {18'h0, rows[i].ovr, rows[i].pos, rows[i].mag}, "result reg");
         $display("row %0d done", i);
      end
      lastPins = busLine;
      // Status through the analog phases
      analogPhase <= `ARP_PH_INTEGRATE;
      repeat (2) @(posedge clk);
      chk(statusOut, 1'b1, "status integrate");
      analogPhase <= `ARP_PH_DEINTEGRATE;
      repeat (2) @(posedge clk);
      chk(statusOut, 1'b1, "status deintegrate");
      convert(12'h3C3, 1'b0, 1'b1);
      chk(statusOut, 1'b0, "status after latch");
      chk(busLine, {2'b10, 12'h3C3}, "pins negative");
      analogPhase <= `ARP_PH_INTEGRATE;
      repeat (2) @(posedge clk);
      analogPhase <= `ARP_PH_ZERO_INTEG;
      repeat (2) @(posedge clk);
      chk(statusOut, 1'b0, "status zero integ");
      analogPhase <= `ARP_PH_INTEGRATE;
      repeat (2) @(posedge clk);
      analogPhase <= `ARP_PH_AUTO_ZERO;
      repeat (2) @(posedge clk);
      chk(statusOut, 1'b0, "status auto zero");
      $display("status test done");
      // Hold bit blocks a new result
      lastPins = busLine;
      avXfer(1'b1, `ARP_OFF_CTRL, 32'h1, q);
      avXfer(1'b0, `ARP_OFF_CTRL, 32'h0, q);
      chk(q, 32'h0000_0001, "ctrl reg");
      convert(12'h123, 1'b1, 1'b0);
      nLatched--;
      chk(busLine, lastPins, "held pins");
      avXfer(1'b1, `ARP_OFF_CTRL, 32'h0, q);
      avXfer(1'b0, `ARP_OFF_STATE, 32'h0, q);
      chk(q, {16'h0000, nLatched[7:0], 5'h00, 1'b0, `ARP_PH_AUTO_ZERO}, "state reg");
      avXfer(1'b0, 4'hC, 32'h0, q);
      chk(q, 32'h0, "unmapped read");
      $display("register test done");
      // Byte groups and master release
      wantHigh <= 1'b0;
      repeat (3) @(posedge clk);
      chk({overrangeOeN, polarityOeN, resultOeN}, 14'h3F00, "low group");
      wantHigh <= 1'b1;
      wantLow  <= 1'b0;
      repeat (3) @(posedge clk);
      chk({overrangeOeN, polarityOeN, resultOeN}, 14'h00FF, "high group");
      wantLow <= 1'b1;
      chipOn  <= 1'b0;
      repeat (3) @(posedge clk);
      chk({overrangeOeN, polarityOeN, resultOeN}, 14'h3FFF, "master off");
      $display("enable test done");
      // Second reset in mid-run releases every pin
      chipOn  <= 1'b1;
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk({overrangeOeN, polarityOeN, resultOeN}, 14'h3FFF, "mid reset");
      reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk({busLine, overrangeOeN, polarityOeN, resultOeN}, 28'h0000000, "pins after reset");
      $display("reset test done");
      conclude();
   end
endmodule
